//--- src/dram_col_timing.v
`timescale 1ns/10ps
`default_nettype none
`include "dram_col_map.vh"
module dram_col_timing (
    // clock and reset
    input  wire                 mclk_in,
    input  wire                 rst_n_in,
    // register port
    input  wire [3:0]           reg_addr_in,
    input  wire [31:0]          reg_wdata_in,
    input  wire                 reg_wr_in,
    input  wire                 reg_rd_in,
    output reg  [31:0]          reg_rdata_out,
    // link pins
    input  wire                 link_ck_in,
    input  wire                 cke_in,
    input  wire [2:0]           cmd_in,
    input  wire                 burst_select_address_bit_in,
    input  wire [`DATA_W-1:0]   dq_in,
    output reg  [`DATA_W-1:0]   dq_out,
    output reg                  dq_oe_out,
    output reg                  dqs_out,
    output reg                  dqs_oe_out,
    // user side
    input  wire [`DATA_W-1:0]   rd_word_in,
    output wire [`DATA_W-1:0]   wr_word_out,
    output wire                 wr_valid_out,
    input  wire                 wr_ready_in,
    output reg                  wr_ref_out,
    output reg                  power_down_termination_window_out
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_LAT   = 3'h1;
    localparam ST_BURST = 3'h2;
    localparam ST_TAIL  = 3'h3;
    localparam ST_POST  = 3'h4;
    // pin synchronisers, three stages each
    reg [13:0] s1_q;
    reg [13:0] s2_q;
    reg [13:0] s3_q;
    wire [13:0] pins = {cke_in, dq_in, burst_select_address_bit_in, cmd_in, link_ck_in};
    reg         ck_lvl_q;
    reg         cke_lvl_q;
    wire        ck_rise = (s2_q[0] == s3_q[0]) && s3_q[0] && !ck_lvl_q;
    wire        ck_fall = (s2_q[0] == s3_q[0]) && !s3_q[0] && ck_lvl_q;
    wire [2:0]  cmd_s   = s3_q[3:1];
    wire        bsel_s  = s3_q[4];
    wire [7:0]  dq_s    = s3_q[12:5];
    wire        cke_s   = s3_q[13];

    reg [31:0]  mode_register_zero_q;
    reg         overflow_q;
    reg [2:0]   state_q;
    reg         is_write_q;
    reg         chop_q;
    reg [4:0]   lat_q;
    reg [3:0]   beat_q;
    reg [2:0]   tail_q;
    reg [4:0]   pd_q;
    reg         cap_valid_q;
    reg [7:0]   cap_word_q;
    wire        buf_ready;

    wire [1:0]  burst_field = mode_register_zero_q[`MR_BURST_LSB+1:`MR_BURST_LSB];
    wire [3:0]  cas_latency = mode_register_zero_q[`MR_CL_LSB+3:`MR_CL_LSB];
    wire [3:0]  cas_write_latency = mode_register_zero_q[`MR_CWL_LSB+3:`MR_CWL_LSB];
    wire [1:0]  al_sel = mode_register_zero_q[`MR_AL_LSB+1:`MR_AL_LSB];
    reg  [4:0]  additive_latency;
    wire [4:0]  read_latency  = additive_latency + {1'b0, cas_latency};
    wire [4:0]  write_latency = additive_latency + {1'b0, cas_write_latency};
    reg         chop_d;
    wire        col_cmd = ck_rise && (state_q == ST_IDLE) &&
                          ((cmd_s == `CMD_READ) || (cmd_s == `CMD_WRITE));
    wire [3:0]  last_beat = chop_q ? (`BEATS_CHOP - 4'h1) : (`BEATS_EIGHT - 4'h1);

    always @* begin
        case (al_sel)
            `AL_CL_MINUS_ONE: additive_latency = {1'b0, cas_latency} - 5'h1;
            `AL_CL_MINUS_TWO: additive_latency = {1'b0, cas_latency} - 5'h2;
            default:          additive_latency = 5'h0;
        endcase
    end

    // burst length taken fresh from each column command
    always @* begin
        case (burst_field)
            `BURST_FIXED_EIGHT: chop_d = 1'b0;
            `BURST_OTF:         chop_d = !bsel_s;
            `BURST_FIXED_CHOP:  chop_d = 1'b1;
            default:            chop_d = 1'b0;
        endcase
    end

    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            s1_q      <= 14'h0;
            s2_q      <= 14'h0;
            s3_q      <= 14'h0;
            ck_lvl_q  <= 1'b0;
            cke_lvl_q <= 1'b0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q[0] == s3_q[0])
                ck_lvl_q <= s3_q[0];
            if (s2_q[13] == s3_q[13])
                cke_lvl_q <= s3_q[13];
        end
    end

    // register port
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            mode_register_zero_q <= `MR_RESET;
            reg_rdata_out        <= 32'h0;
        end else begin
            if (reg_wr_in && reg_addr_in == `REG_MODE_ZERO)
                mode_register_zero_q <= reg_wdata_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `REG_MODE_ZERO: reg_rdata_out <= mode_register_zero_q;
                    `REG_STATUS:    reg_rdata_out <= {23'h0, overflow_q, 3'h0, chop_q, 1'b0, state_q};
                    default:        reg_rdata_out <= 32'h0;
                endcase
            end else begin
                reg_rdata_out <= 32'h0;
            end
        end
    end

    // overflow: set wins over a software clear
    always @(posedge mclk_in) begin
        if (!rst_n_in)
            overflow_q <= 1'b0;
        else if (cap_valid_q && !buf_ready)
            overflow_q <= 1'b1;
        else if (reg_wr_in && reg_addr_in == `REG_STATUS && reg_wdata_in[`ST_OVERFLOW_BIT])
            overflow_q <= 1'b0;
    end

    // column sequencer
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state_q     <= ST_IDLE;
            is_write_q  <= 1'b0;
            chop_q      <= 1'b0;
            lat_q       <= 5'h0;
            beat_q      <= 4'h0;
            tail_q      <= 3'h0;
            cap_valid_q <= 1'b0;
            cap_word_q  <= 8'h0;
            dq_out      <= 8'h0;
            dq_oe_out   <= 1'b0;
            dqs_out     <= 1'b0;
            dqs_oe_out  <= 1'b0;
            wr_ref_out  <= 1'b0;
        end else begin
            cap_valid_q <= 1'b0;
            wr_ref_out  <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    dqs_oe_out <= 1'b0;
                    dqs_out    <= 1'b0;
                    if (col_cmd) begin
                        is_write_q <= (cmd_s == `CMD_WRITE);
                        chop_q     <= chop_d;
                        lat_q      <= (cmd_s == `CMD_WRITE) ? write_latency : read_latency;
                        beat_q     <= 4'h0;
                        state_q    <= ST_LAT;
                    end
                end
                ST_LAT: begin
                    if (ck_rise) begin
                        lat_q <= lat_q - 5'h1;
                        if (lat_q == 5'h1) begin
                            state_q <= ST_BURST;
                            beat_q  <= 4'h1;
                            if (is_write_q) begin
                                cap_word_q  <= dq_s;
                                cap_valid_q <= 1'b1;
                            end else begin
                                dq_out     <= rd_word_in;
                                dq_oe_out  <= 1'b1;
                                dqs_out    <= 1'b1;
                                dqs_oe_out <= 1'b1;
                            end
                        end
                    end
                end
                ST_BURST: begin
                    if (ck_rise || ck_fall) begin
                        beat_q <= beat_q + 4'h1;
                        if (is_write_q) begin
                            cap_word_q  <= dq_s;
                            cap_valid_q <= 1'b1;
                        end else begin
                            dq_out  <= rd_word_in;
                            dqs_out <= ck_rise;
                        end
                        if (beat_q == last_beat) begin
                            state_q <= is_write_q ? ST_TAIL : ST_POST;
                            tail_q  <= (chop_q && burst_field == `BURST_OTF) ?
                                       (`CHOP_TAIL_CLOCKS - `CHOP_BURST_CLOCKS) : 3'h0;
                        end
                    end
                end
                ST_TAIL: begin
                    // reference edge; fixed chops use the edge right after their last beat
                    if (ck_rise) begin
                        if (tail_q == 3'h0) begin
                            wr_ref_out <= 1'b1;
                            state_q    <= ST_IDLE;
                        end else begin
                            tail_q <= tail_q - 3'h1;
                        end
                    end
                end
                ST_POST: begin
                    dq_oe_out <= 1'b0;
                    dqs_out   <= 1'b0;
                    if (ck_fall)
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // power-down entry window for termination timing
    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pd_q                              <= 5'h0;
            power_down_termination_window_out <= 1'b0;
        end else begin
            if (cke_lvl_q && (s2_q[13] == s3_q[13]) && !cke_s)
                pd_q <= write_latency - 5'h1;
            else if (ck_rise && pd_q != 5'h0)
                pd_q <= pd_q - 5'h1;
            power_down_termination_window_out <= (pd_q != 5'h0);
        end
    end

    two_entry_buffer #(
        .WIDTH(`DATA_W)
    ) i_two_entry_buffer (
        .mclk_in      (mclk_in),
        .rst_n_in     (rst_n_in),
        .in_data_in   (cap_word_q),
        .in_valid_in  (cap_valid_q),
        .in_ready_out (buf_ready),
        .out_data_out (wr_word_out),
        .out_valid_out(wr_valid_out),
        .out_ready_in (wr_ready_in)
    );
endmodule
`default_nettype wire

//--- pkg/dram_col_map.vh
`ifndef DRAM_COL_MAP_VH
`define DRAM_COL_MAP_VH
// register indices on the plain register port
`define REG_MODE_ZERO     4'h0
`define REG_STATUS        4'h1
// mode_register_zero fields
`define MR_BURST_LSB      0
`define MR_CL_LSB         4
`define MR_CWL_LSB        8
`define MR_AL_LSB         12
`define MR_RESET          32'h0000_0550
// burst field encodings
`define BURST_FIXED_EIGHT 2'h0
`define BURST_OTF         2'h1
`define BURST_FIXED_CHOP  2'h2
// additive latency select: 0, cl-1, cl-2
`define AL_ZERO           2'h0
`define AL_CL_MINUS_ONE   2'h1
`define AL_CL_MINUS_TWO   2'h2
// status fields
`define ST_OVERFLOW_BIT   8
`define ST_CHOP_BIT       4
// column commands on the command pins
`define CMD_READ          3'h1
`define CMD_WRITE         3'h2
// beats per burst and chopped-write reference offset in link clocks
`define BEATS_EIGHT       4'h8
`define BEATS_CHOP        4'h4
`define CHOP_TAIL_CLOCKS  3'h4
`define CHOP_BURST_CLOCKS 3'h2
`define DATA_W            8
`endif

//--- src/two_entry_buffer.v
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             mclk_in,
    input  wire             rst_n_in,
    // fill side
    input  wire [WIDTH-1:0] in_data_in,
    input  wire             in_valid_in,
    output wire             in_ready_out,
    // drain side
    output wire [WIDTH-1:0] out_data_out,
    output wire             out_valid_out,
    input  wire             out_ready_in
);
    reg [WIDTH-1:0] head_q;
    reg             head_valid_q;
    reg [WIDTH-1:0] skid_q;
    reg             skid_valid_q;
    // head slot can take a word when empty or being drained this cycle
    wire            head_free = !head_valid_q || out_ready_in;

    // drain side comes straight from the head flops
    assign in_ready_out  = !skid_valid_q;
    assign out_valid_out = head_valid_q;
    assign out_data_out  = head_q;

    always @(posedge mclk_in) begin
        if (!rst_n_in) begin
            head_q       <= {WIDTH{1'b0}};
            head_valid_q <= 1'b0;
            skid_q       <= {WIDTH{1'b0}};
            skid_valid_q <= 1'b0;
        end else if (head_free) begin
            if (skid_valid_q) begin
                head_q       <= skid_q;
                head_valid_q <= 1'b1;
                skid_valid_q <= 1'b0;
            end else begin
                head_q       <= in_data_in;
                head_valid_q <= in_valid_in;
            end
        end else if (in_valid_in && !skid_valid_q) begin
            // stalled head: park the word in the second entry
            skid_q       <= in_data_in;
            skid_valid_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- sim/col_timing_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "dram_col_map.vh"
module col_timing_props (
    // clock and reset
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    // watched ports
    input wire logic [3:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        link_ck_in,
    input wire logic        cke_in,
    input wire logic [2:0]  cmd_in,
    input wire logic        burst_select_address_bit_in,
    input wire logic        dqs_out,
    input wire logic        dqs_oe_out,
    input wire logic        wr_valid_out,
    input wire logic        wr_ref_out,
    input wire logic        power_down_termination_window_out
);
    logic [31:0] mode_q;
    logic [4:0]  rcnt_q, wcnt_q, pcnt_q;
    logic [3:0]  dcnt_q;
    logic        lk_q, dqs_q, chop_q, wpend_q;
    wire  [4:0]  cas_l = {1'b0, mode_q[7:4]};
    wire  [4:0]  add_l = mode_q[13:12] == 2'h1 ? cas_l - 5'h1 : mode_q[13:12] == 2'h2 ? cas_l - 5'h2 : 5'h0;
    wire  [4:0]  lat_w = add_l + {1'b0, mode_q[11:8]};
    wire         rise = link_ck_in & ~lk_q;
    wire         col = rise && (cmd_in == `CMD_READ || cmd_in == `CMD_WRITE);
    wire         chop = mode_q[1:0] == `BURST_FIXED_CHOP || (mode_q[1:0] == `BURST_OTF && !burst_select_address_bit_in);
    // link rises counted from each column command and from the power-down entry
    always @(posedge mclk_in) begin
        lk_q <= link_ck_in;
        dqs_q <= dqs_out;
        if (!rst_n_in) mode_q <= `MR_RESET;
        else if (reg_wr_in && reg_addr_in == `REG_MODE_ZERO) mode_q <= reg_wdata_in;
        if (rise) rcnt_q <= cmd_in == `CMD_READ ? 5'h0 : rcnt_q + 5'h1;
        if (rise) wcnt_q <= cmd_in == `CMD_WRITE ? 5'h0 : wcnt_q + 5'h1;
        if (cke_in) pcnt_q <= 5'h0;
        else if (rise) pcnt_q <= pcnt_q + 5'h1;
        if (col) chop_q <= chop;
        dcnt_q <= !dqs_oe_out ? 4'h0 : dcnt_q + {3'h0, dqs_out & ~dqs_q};
        wpend_q <= rise && cmd_in == `CMD_WRITE ? 1'b1 : wr_valid_out ? 1'b0 : wpend_q;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence read_done;
        dqs_oe_out ##1 !dqs_oe_out;
    endsequence
    a_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("stray read data");
    a_mode_readback: assert property ($past(reg_rd_in && reg_addr_in == 4'h0) |-> reg_rdata_out == mode_q)
        else $error("bad mode readback");
    a_read_beats: assert property (read_done |-> dcnt_q == (chop_q ? 4'h2 : 4'h4))
        else $error("bad read length");
    a_strobe_idle_low: assert property (!dqs_oe_out |-> !dqs_out)
        else $error("strobe not low");
    a_read_latency: assert property ($rose(dqs_oe_out) |-> rcnt_q == add_l + cas_l)
        else $error("bad read latency");
    a_write_latency: assert property ($rose(wr_valid_out) && wpend_q |-> wcnt_q == lat_w)
        else $error("bad write latency");
    a_write_ref: assert property (wr_ref_out |-> wcnt_q == lat_w + (chop_q && mode_q[1:0] == `BURST_FIXED_CHOP ? 5'h2 : 5'h4))
        else $error("bad write reference");
    a_window_length: assert property ($fell(power_down_termination_window_out) |-> pcnt_q == lat_w - 5'h1)
        else $error("bad window length");
endmodule
bind dram_col_timing col_timing_props i_col_timing_props (.mclk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .link_ck_in, .cke_in, .cmd_in, .burst_select_address_bit_in,
    .dqs_out, .dqs_oe_out, .wr_valid_out, .wr_ref_out, .power_down_termination_window_out);
`default_nettype wire

//--- sim/col_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "dram_col_map.vh"
module col_ctrl_model (
    // link pins toward the device
    output logic       link_ck_out,
    output logic       cke_out,
    output logic [2:0] cmd_out,
    output logic       bsel_out,
    output logic [7:0] dq_out
);
    initial begin
        link_ck_out = 1'b0;
        cke_out = 1'b1;
        cmd_out = 3'h0;
        bsel_out = 1'b0;
        dq_out = 8'h00;
    end
    // free running at eight mclk periods per link clock, every link edge falling on an mclk falling edge
    always #80 link_ck_out = ~link_ck_out;
    task automatic col_cmd(input [2:0] c, input b, input [4:0] lat, input [3:0] n);
        integer k;
        @(negedge link_ck_out);
        cmd_out = c;
        bsel_out = b;
        @(negedge link_ck_out);
        cmd_out = 3'h0;
        bsel_out = ~b;
        if (c == `CMD_WRITE) begin
            repeat (lat - 5'h1) @(negedge link_ck_out);
            // data settles midway between link edges, one beat per edge
            for (k = 0; k < n; k++) begin
                #40 dq_out = 8'h40 + k[7:0];
                @(link_ck_out);
            end
            #40 dq_out = ~dq_out;
        end
    endtask
    task automatic power_down;
        @(negedge link_ck_out);
        cke_out = 1'b0;
        repeat (12) @(posedge link_ck_out);
        cke_out = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- sim/dram_col_timing_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "dram_col_map.vh"
module dram_col_timing_bench;
    logic        mclk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, wr_ready_in = 1'b1;
    logic [3:0]  reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, rd;
    logic [7:0]  rd_word_in = 8'h3c, dq_in, dq_out, wr_word_out, exp_w;
    logic [2:0]  cmd;
    logic        ck, cke, bsel, dq_oe_out, dqs_out, dqs_oe_out, wr_valid_out, wr_ref_out, pdw;
    integer      failures = 0, cmp_count = 0, nw = 0, i;
    always #10 mclk_in = ~mclk_in;
    dram_col_timing i_dram_col_timing (.mclk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .link_ck_in(ck), .cke_in(cke), .cmd_in(cmd),
        .burst_select_address_bit_in(bsel), .dq_in, .dq_out, .dq_oe_out, .dqs_out, .dqs_oe_out,
        .rd_word_in, .wr_word_out, .wr_valid_out, .wr_ready_in, .wr_ref_out,
        .power_down_termination_window_out(pdw));
    col_ctrl_model i_col_ctrl_model (.link_ck_out(ck), .cke_out(cke), .cmd_out(cmd), .bsel_out(bsel),
        .dq_out(dq_in));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input [3:0] a, input [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic reg_read(input [3:0] a);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(posedge mclk_in);
        rd = reg_rdata_out;
    endtask
    // captured write words must come out in order
    always @(posedge mclk_in) begin
        if (wr_valid_out && wr_ready_in) begin
            cmp(wr_word_out, exp_w);
            exp_w <= exp_w + 8'h1;
            nw <= nw + 1;
        end
        if (dq_oe_out) cmp(dq_out, rd_word_in);
    end
    task automatic burst(input [31:0] m, input b, input [2:0] c);
        logic [4:0] cas_l, add_l, lat_w;
        logic [3:0] n;
        cas_l = {1'b0, m[7:4]};
        add_l = m[13:12] == 2'h1 ? cas_l - 5'h1 : m[13:12] == 2'h2 ? cas_l - 5'h2 : 5'h0;
        lat_w = add_l + {1'b0, m[11:8]};
        n = m[1:0] == `BURST_FIXED_CHOP || (m[1:0] == `BURST_OTF && !b) ? 4'h4 : 4'h8;
        reg_write(`REG_MODE_ZERO, m);
        reg_read(`REG_MODE_ZERO);
        cmp(rd, m);
        nw = 0;
        exp_w = 8'h40;
        rd_word_in <= rd_word_in + 8'h11;
        i_col_ctrl_model.col_cmd(c, b, lat_w, n);
        if (c == `CMD_WRITE) begin
            for (i = 0; i < 400 && !wr_ref_out; i++) @(posedge mclk_in);
            cmp(wr_ref_out, 1'b1);
            repeat (8) @(posedge mclk_in);
            if (wr_ready_in) cmp(nw, n);
        end else begin
            for (i = 0; i < 400 && !dqs_oe_out; i++) @(posedge mclk_in);
            cmp(dqs_oe_out, 1'b1);
            for (i = 0; i < 80 && dqs_oe_out; i++) @(posedge mclk_in);
            cmp(dqs_oe_out, 1'b0);
            repeat (8) @(posedge mclk_in);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        print_verdict;
    end
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        reg_read(`REG_MODE_ZERO);
        cmp(rd, `MR_RESET);
        reg_read(4'h7);
        cmp(rd, 32'h0);
        burst(32'h550, 1'b0, `CMD_WRITE);
        burst(32'h551, 1'b0, `CMD_WRITE);
        burst(32'h551, 1'b1, `CMD_READ);
        burst(32'h551, 1'b0, `CMD_READ);
        burst(32'h552, 1'b1, `CMD_WRITE);
        burst(32'h552, 1'b1, `CMD_READ);
        burst(32'h1550, 1'b1, `CMD_READ);
        burst(32'h2550, 1'b1, `CMD_WRITE);
        i_col_ctrl_model.power_down;
        wr_ready_in <= 1'b0;
        burst(32'h550, 1'b1, `CMD_WRITE);
        i_col_ctrl_model.power_down;
        reg_read(`REG_STATUS);
        cmp(rd[`ST_OVERFLOW_BIT], 1'b1);
        wr_ready_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        cmp(nw, 2);
        reg_write(`REG_STATUS, 32'h100);
        reg_read(`REG_STATUS);
        cmp(rd[`ST_OVERFLOW_BIT], 1'b0);
        print_verdict;
    end
endmodule
`default_nettype wire
